// [hdl/mrdac_dac_chan.sv]
// one dac channel: low and high code registers and the channel code
`default_nettype none
module mrdac_dac_chan
#(
  parameter int DAC_BITS = mrdac_pkg::DAC_BITS_DFLT
)
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // register writes
  input  wire logic                wrLow,
  input  wire logic                wrHigh,
  input  wire logic [7:0]          wdata,
  // register read-back and code
  output logic      [7:0]          lowByte,
  output logic      [7:0]          highByte,
  output logic      [DAC_BITS-1:0] code
);

  localparam int LOW_W = DAC_BITS - 8;

  logic [LOW_W-1:0] low_q;
  logic [LOW_W-1:0] low_d;
  logic [7:0]       high_q;
  logic [7:0]       high_d;

  // low bits live in the top of the low register
  always_comb
  begin
    low_d  = wrLow ? wdata[7 -: LOW_W] : low_q;
    high_d = wrHigh ? wdata : high_q;
  end

  // code registers, zero at power-up so the output starts at 0 v
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_q  <= mrdac_pkg::RESET_BYTE[7 -: LOW_W];
      high_q <= mrdac_pkg::RESET_BYTE;
    end
    else
    begin
      low_q  <= low_d;
      high_q <= high_d;
    end
  end

  // unused low bits read zero
  assign lowByte  = {low_q, {(8 - LOW_W){1'b0}}};
  assign highByte = high_q;
  assign code     = {high_q, low_q};

  a_low_field : assert property (@(posedge mclk) disable iff (!resetn)
    wrLow |=> code[LOW_W-1:0] == $past(wdata[7 -: LOW_W]) && lowByte[7-LOW_W:0] == '0)
    else $error("dac low bits not taken from top of written byte");

  a_high_field : assert property (@(posedge mclk) disable iff (!resetn)
    wrHigh |=> code[DAC_BITS-1 -: 8] == $past(wdata))
    else $error("dac high byte not placed above low bits");

endmodule : mrdac_dac_chan
`default_nettype wire

// [hdl/mrdac_pkg.sv]
// constants for the monitor result and dac code register bank
`default_nettype none
package mrdac_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_INT_LOW   = 6'h03;
  localparam logic [5:0] IDX_RES_LOW   = 6'h04;
  localparam logic [5:0] IDX_INT_TEMP  = 6'h07;
  localparam logic [5:0] IDX_EXT_IN1   = 6'h08;
  localparam logic [5:0] IDX_IN2       = 6'h09;
  localparam logic [5:0] IDX_IN3       = 6'h0a;
  localparam logic [5:0] IDX_IN4       = 6'h0b;
  localparam logic [5:0] IDX_DACA_LO   = 6'h10;
  localparam logic [5:0] IDX_DACA_HI   = 6'h11;
  localparam logic [5:0] IDX_DACB_LO   = 6'h12;
  localparam logic [5:0] IDX_DACB_HI   = 6'h13;
  localparam logic [5:0] IDX_INPUT_SEL = 6'h18;

  // input select field codes and position
  localparam logic [1:0] SEL_INPUTS    = 2'h0;
  localparam logic [1:0] SEL_EXT_DIODE = 2'h2;
  localparam logic [1:0] SEL_RESET     = SEL_INPUTS;
  localparam int         SEL_POS       = 1;

  // result channel codes from the converter
  localparam logic [2:0] CH_INT_TEMP = 3'h0;
  localparam logic [2:0] CH_EXT_TEMP = 3'h1;
  localparam logic [2:0] CH_IN1      = 3'h2;
  localparam logic [2:0] CH_IN2      = 3'h3;
  localparam logic [2:0] CH_IN3      = 3'h4;
  localparam logic [2:0] CH_IN4      = 3'h5;

  // result storage slots
  localparam int         NUM_SLOTS = 5;
  localparam logic [2:0] SLOT_INT  = 3'h0;
  localparam logic [2:0] SLOT_EXT  = 3'h1;
  localparam logic [2:0] SLOT_IN2  = 3'h2;
  localparam logic [2:0] SLOT_IN3  = 3'h3;
  localparam logic [2:0] SLOT_IN4  = 3'h4;
  localparam logic [2:0] SLOT_NONE = 3'h7;

  // widths and reset values
  localparam int         RESULT_W      = 10;
  localparam int         DAC_BITS_DFLT = 12;
  localparam logic [7:0] RESET_BYTE    = 8'h00;

endpackage : mrdac_pkg
`default_nettype wire

// [hdl/mrdac_regs.sv]
// apb register bank holding conversion results and dac a/b codes
`default_nettype none
// How it works
// - internal temperature high byte at 0x07
// - 0x08 holds external or input one
// - select code 00 inputs, 10 diode
// - diode result stored at 0x08 when selected
// - input two low bits at 0x04 D3:D2
// - input three low bits at 0x04 D5:D4
// - input four low bits at 0x04 D7:D6
// - dac low bits in top of register
// - high byte above low bits drives output
// - everything resets to zero, outputs 0 v
// - dac a 0x10/0x11, dac b 0x12/0x13
module mrdac_regs
#(
  parameter int DAC_BITS = mrdac_pkg::DAC_BITS_DFLT
)
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // conversion results from the converter
  input  wire logic                resValid,
  input  wire logic [2:0]          resChannel,
  input  wire logic [9:0]          resValue,
  // analog side
  output logic      [1:0]          inputSelectField,
  output logic      [DAC_BITS-1:0] dacOutputA,
  output logic      [DAC_BITS-1:0] dacOutputB
);

  // true for every index that answers without error
  function automatic logic isMapped(input logic [5:0] idx);
    unique case (idx)
      mrdac_pkg::IDX_INT_LOW,
      mrdac_pkg::IDX_RES_LOW,
      mrdac_pkg::IDX_INT_TEMP,
      mrdac_pkg::IDX_EXT_IN1,
      mrdac_pkg::IDX_IN2,
      mrdac_pkg::IDX_IN3,
      mrdac_pkg::IDX_IN4,
      mrdac_pkg::IDX_DACA_LO,
      mrdac_pkg::IDX_DACA_HI,
      mrdac_pkg::IDX_DACB_LO,
      mrdac_pkg::IDX_DACB_HI,
      mrdac_pkg::IDX_INPUT_SEL: return 1'b1;
      default:                  return 1'b0;
    endcase
  endfunction : isMapped

  // true for the read-only result indices
  function automatic logic isResult(input logic [5:0] idx);
    return idx == mrdac_pkg::IDX_INT_LOW || idx == mrdac_pkg::IDX_RES_LOW
        || (idx >= mrdac_pkg::IDX_INT_TEMP && idx <= mrdac_pkg::IDX_IN4);
  endfunction : isResult

  // storage slot for a channel under the current input selection
  function automatic logic [2:0] resultSlot(input logic [2:0] ch,
                                            input logic [1:0] sel);
    case (ch)
      mrdac_pkg::CH_INT_TEMP: return mrdac_pkg::SLOT_INT;
      mrdac_pkg::CH_EXT_TEMP:
        return (sel == mrdac_pkg::SEL_EXT_DIODE) ? mrdac_pkg::SLOT_EXT
                                                 : mrdac_pkg::SLOT_NONE;
      mrdac_pkg::CH_IN1:
        return (sel == mrdac_pkg::SEL_INPUTS) ? mrdac_pkg::SLOT_EXT
                                              : mrdac_pkg::SLOT_NONE;
      mrdac_pkg::CH_IN2:      return mrdac_pkg::SLOT_IN2;
      mrdac_pkg::CH_IN3:      return mrdac_pkg::SLOT_IN3;
      mrdac_pkg::CH_IN4:      return mrdac_pkg::SLOT_IN4;
      default:                return mrdac_pkg::SLOT_NONE;
    endcase
  endfunction : resultSlot

  localparam int SLOTS = mrdac_pkg::NUM_SLOTS;
  localparam int RW    = mrdac_pkg::RESULT_W;

  logic [5:0]            idx;
  logic                  aligned;
  logic                  setupPh;
  logic                  accessPh;
  logic                  wrEn;
  logic [2:0]            slot;
  logic [SLOTS-1:0][RW-1:0] res_q;
  logic [SLOTS-1:0][RW-1:0] res_d;
  logic [1:0]            sel_q;
  logic [1:0]            sel_d;
  logic [1:0]            selWr;
  logic [31:0]           prdata_q;
  logic [31:0]           prdata_d;
  logic                  err_q;
  logic                  err_d;
  logic [7:0]            rdByte;
  logic [7:0]            dacALow;
  logic [7:0]            dacAHigh;
  logic [7:0]            dacBLow;
  logic [7:0]            dacBHigh;

  // apb phase and address decode
  assign idx      = paddr[7:2];
  assign aligned  = paddr[1:0] == 2'h0;
  assign setupPh  = psel && !penable;
  assign accessPh = psel && penable;
  assign wrEn     = accessPh && pwrite && aligned && pstrb[0];
  assign pready   = 1'b1;  // zero wait states
  assign slot     = resultSlot(resChannel, sel_q);
  assign selWr    = pwdata[mrdac_pkg::SEL_POS +: 2];

  // result capture; only the converter loads results, never the bus
  always_comb
  begin
    res_d = res_q;
    if (resValid && slot != mrdac_pkg::SLOT_NONE)
    begin
      res_d[slot] = resValue;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      res_q <= '0;
    end
    else
    begin
      res_q <= res_d;
    end
  end

  // input select field; undefined codes are dropped
  always_comb
  begin
    sel_d = sel_q;
    if (wrEn && idx == mrdac_pkg::IDX_INPUT_SEL
        && (selWr == mrdac_pkg::SEL_INPUTS || selWr == mrdac_pkg::SEL_EXT_DIODE))
    begin
      sel_d = selWr;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_q <= mrdac_pkg::SEL_RESET;
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  assign inputSelectField = sel_q;

  // dac channels a and b
  mrdac_dac_chan #(
    .DAC_BITS (DAC_BITS)
  ) u_dac_a (
    .mclk     (mclk),
    .resetn   (resetn),
    .wrLow    (wrEn && idx == mrdac_pkg::IDX_DACA_LO),
    .wrHigh   (wrEn && idx == mrdac_pkg::IDX_DACA_HI),
    .wdata    (pwdata[7:0]),
    .lowByte  (dacALow),
    .highByte (dacAHigh),
    .code     (dacOutputA)
  );

  mrdac_dac_chan #(
    .DAC_BITS (DAC_BITS)
  ) u_dac_b (
    .mclk     (mclk),
    .resetn   (resetn),
    .wrLow    (wrEn && idx == mrdac_pkg::IDX_DACB_LO),
    .wrHigh   (wrEn && idx == mrdac_pkg::IDX_DACB_HI),
    .wdata    (pwdata[7:0]),
    .lowByte  (dacBLow),
    .highByte (dacBHigh),
    .code     (dacOutputB)
  );

  // read multiplexer; high bytes carry value bits 9:2
  always_comb
  begin
    rdByte = 8'h00;
    case (idx)
      mrdac_pkg::IDX_INT_LOW:   rdByte = {6'h00, res_q[mrdac_pkg::SLOT_INT][1:0]};
      mrdac_pkg::IDX_RES_LOW:   rdByte = {res_q[mrdac_pkg::SLOT_IN4][1:0],
                                          res_q[mrdac_pkg::SLOT_IN3][1:0],
                                          res_q[mrdac_pkg::SLOT_IN2][1:0],
                                          res_q[mrdac_pkg::SLOT_EXT][1:0]};
      mrdac_pkg::IDX_INT_TEMP:  rdByte = res_q[mrdac_pkg::SLOT_INT][9:2];
      mrdac_pkg::IDX_EXT_IN1:   rdByte = res_q[mrdac_pkg::SLOT_EXT][9:2];
      mrdac_pkg::IDX_IN2:       rdByte = res_q[mrdac_pkg::SLOT_IN2][9:2];
      mrdac_pkg::IDX_IN3:       rdByte = res_q[mrdac_pkg::SLOT_IN3][9:2];
      mrdac_pkg::IDX_IN4:       rdByte = res_q[mrdac_pkg::SLOT_IN4][9:2];
      mrdac_pkg::IDX_DACA_LO:   rdByte = dacALow;
      mrdac_pkg::IDX_DACA_HI:   rdByte = dacAHigh;
      mrdac_pkg::IDX_DACB_LO:   rdByte = dacBLow;
      mrdac_pkg::IDX_DACB_HI:   rdByte = dacBHigh;
      mrdac_pkg::IDX_INPUT_SEL: rdByte = {5'h00, sel_q, 1'b0};
      default:                  rdByte = 8'h00;
    endcase
  end

  // read data and error are captured in the setup cycle
  always_comb
  begin
    prdata_d = prdata_q;
    err_d    = accessPh ? err_q : 1'b0;
    if (setupPh)
    begin
      prdata_d = pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
      err_d    = !(aligned && isMapped(idx));
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      err_q    <= err_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = err_q && accessPh;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_reset_zero : assert property (
    !$past(resetn) |-> res_q == '0 && dacOutputA == '0 && dacOutputB == '0
                       && sel_q == mrdac_pkg::SEL_RESET)
    else $error("state not zero after reset release");

  a_int_store : assert property (
    resValid && resChannel == mrdac_pkg::CH_INT_TEMP
    |=> res_q[mrdac_pkg::SLOT_INT] == $past(resValue))
    else $error("internal temperature result not stored");

  a_ext_gated : assert property (
    resValid && resChannel == mrdac_pkg::CH_EXT_TEMP
    && sel_q != mrdac_pkg::SEL_EXT_DIODE |=> $stable(res_q[mrdac_pkg::SLOT_EXT]))
    else $error("external result stored while inputs selected");

  a_ext_store : assert property (
    resValid && resChannel == mrdac_pkg::CH_EXT_TEMP
    && sel_q == mrdac_pkg::SEL_EXT_DIODE
    |=> res_q[mrdac_pkg::SLOT_EXT] == $past(resValue))
    else $error("external result not stored while diode selected");

  a_sel_legal : assert property (
    sel_q == mrdac_pkg::SEL_INPUTS || sel_q == mrdac_pkg::SEL_EXT_DIODE)
    else $error("input select holds undefined code");

  a_in2_pair : assert property (
    setupPh && !pwrite && idx == mrdac_pkg::IDX_RES_LOW
    |=> prdata[3:2] == $past(res_q[mrdac_pkg::SLOT_IN2][1:0]))
    else $error("input two low bits misplaced");

  a_in3_pair : assert property (
    setupPh && !pwrite && idx == mrdac_pkg::IDX_RES_LOW
    |=> prdata[5:4] == $past(res_q[mrdac_pkg::SLOT_IN3][1:0]))
    else $error("input three low bits misplaced");

  a_in4_pair : assert property (
    setupPh && !pwrite && idx == mrdac_pkg::IDX_RES_LOW
    |=> prdata[7:6] == $past(res_q[mrdac_pkg::SLOT_IN4][1:0]))
    else $error("input four low bits misplaced");

  a_dacb_high : assert property (
    wrEn && idx == mrdac_pkg::IDX_DACB_HI
    |=> dacOutputB[DAC_BITS-1 -: 8] == $past(pwdata[7:0]) && $stable(dacOutputA))
    else $error("dac b high byte write misrouted");

  a_ro_ignored : assert property (
    wrEn && isResult(idx) && !resValid |=> $stable(res_q) && $stable(sel_q)
                                           && $stable(dacOutputA) && $stable(dacOutputB))
    else $error("write changed a result register");

  a_unmapped_err : assert property (
    setupPh && !isMapped(idx) ##1 accessPh |-> pslverr && pready)
    else $error("unmapped access did not report error");

  // routing of dac a low bits, select writes, the shared slot and the internal temperature high byte
  a_daca_low : assert property (
    wrEn && idx == mrdac_pkg::IDX_DACA_LO
    |=> dacOutputA[DAC_BITS-9:0] == $past(pwdata[7 -: DAC_BITS-8]) && $stable(dacOutputB))
    else $error("dac a low bits write misrouted");

  a_sel_write : assert property (
    wrEn && idx == mrdac_pkg::IDX_INPUT_SEL
    && (selWr == mrdac_pkg::SEL_INPUTS || selWr == mrdac_pkg::SEL_EXT_DIODE)
    |=> sel_q == $past(selWr))
    else $error("legal select code not taken");

  a_sel_refused : assert property (
    wrEn && idx == mrdac_pkg::IDX_INPUT_SEL
    && !(selWr == mrdac_pkg::SEL_INPUTS || selWr == mrdac_pkg::SEL_EXT_DIODE)
    |=> $stable(sel_q))
    else $error("undefined select code taken");

  a_in1_store : assert property (
    resValid && resChannel == mrdac_pkg::CH_IN1 && sel_q == mrdac_pkg::SEL_INPUTS
    |=> res_q[mrdac_pkg::SLOT_EXT] == $past(resValue))
    else $error("input one result not stored while inputs selected");

  a_in1_gated : assert property (
    resValid && resChannel == mrdac_pkg::CH_IN1 && sel_q == mrdac_pkg::SEL_EXT_DIODE
    |=> $stable(res_q[mrdac_pkg::SLOT_EXT]))
    else $error("input one result stored while diode selected");

  a_int_read : assert property (
    setupPh && !pwrite && idx == mrdac_pkg::IDX_INT_TEMP
    |=> prdata[7:0] == $past(res_q[mrdac_pkg::SLOT_INT][9:2]))
    else $error("internal temperature high byte misplaced");

  c_sel_refused : cover property (wrEn && idx == mrdac_pkg::IDX_INPUT_SEL
    && !(selWr == mrdac_pkg::SEL_INPUTS || selWr == mrdac_pkg::SEL_EXT_DIODE));
  c_ext_diode : cover property (
    resValid && resChannel == mrdac_pkg::CH_EXT_TEMP
    && sel_q == mrdac_pkg::SEL_EXT_DIODE);
  c_dac_write : cover property (wrEn && idx == mrdac_pkg::IDX_DACA_LO);
  c_low_read : cover property (setupPh && !pwrite && idx == mrdac_pkg::IDX_RES_LOW);
  c_unmapped : cover property (accessPh && pslverr);

endmodule : mrdac_regs
`default_nettype wire

// [tb/mrdac_conv_model.sv]
// behavioural converter model feeding result strobes into the bank
`default_nettype none
module mrdac_conv_model
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // result strobe toward the bank
  output logic            resValid,
  output logic      [2:0] resChannel,
  output logic      [9:0] resValue
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle lines carry junk so a stale value is never mistaken for a result
  initial
  begin
    resValid   = 1'b0;
    resChannel = 3'h7;
    resValue   = 10'h155;
  end

  // one-cycle strobe, then the inverse of what was sent
  task automatic send(input logic [2:0] ch, input logic [9:0] v);
    @(posedge mclk);
    resValid   <= 1'b1;
    resChannel <= ch;
    resValue   <= v;
    @(posedge mclk);
    resValid   <= 1'b0;
    resChannel <= ~ch;
    resValue   <= ~v;
  endtask : send
endmodule : mrdac_conv_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking testbench for the result and dac register bank
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, resValid, er;
  logic [7:0]  paddr, lowReg;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [2:0]  resChannel;
  logic [9:0]  resValue;
  logic [1:0]  inputSelectField;
  logic [11:0] dacOutputA, dacOutputB;
  logic [5:0]  allIdx [12];
  logic [5:0]  inIdx [3];
  logic [2:0]  inCh [3];
  logic [9:0]  inVal [3];
  int          n_fail, check_count, cyc;

  mrdac_regs #(.DAC_BITS(12)) mrdac_regs_inst (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .resValid(resValid), .resChannel(resChannel), .resValue(resValue),
    .inputSelectField(inputSelectField), .dacOutputA(dacOutputA), .dacOutputB(dacOutputB));

  mrdac_conv_model mrdac_conv_model_inst (
    .mclk(mclk), .resetn(resetn), .resValid(resValid), .resChannel(resChannel),
    .resValue(resValue));

  // clock and hang guard
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  function automatic logic [7:0] ad(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : ad

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer: setup, then access until pready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);  // a write lands at the access edge; outputs are read one edge later
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // main sequence
  initial
  begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pstrb = 4'h1; n_fail = 0; check_count = 0; cyc = 0; lowReg = 8'h00;
    allIdx = '{mrdac_pkg::IDX_INT_LOW, mrdac_pkg::IDX_RES_LOW, mrdac_pkg::IDX_INT_TEMP,
               mrdac_pkg::IDX_EXT_IN1, mrdac_pkg::IDX_IN2, mrdac_pkg::IDX_IN3,
               mrdac_pkg::IDX_IN4, mrdac_pkg::IDX_DACA_LO, mrdac_pkg::IDX_DACA_HI,
               mrdac_pkg::IDX_DACB_LO, mrdac_pkg::IDX_DACB_HI, mrdac_pkg::IDX_INPUT_SEL};
    inIdx = '{mrdac_pkg::IDX_IN2, mrdac_pkg::IDX_IN3, mrdac_pkg::IDX_IN4};
    inCh  = '{mrdac_pkg::CH_IN2, mrdac_pkg::CH_IN3, mrdac_pkg::CH_IN4};
    inVal = '{10'h1e7, 10'h0b2, 10'h34d};
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    // power-up values
    foreach (allIdx[i]) rd_chk(ad(allIdx[i]), 32'h0);
    chk({20'h0, dacOutputA}, 32'h0);
    chk({20'h0, dacOutputB}, 32'h0);
    chk({30'h0, inputSelectField}, {30'h0, mrdac_pkg::SEL_INPUTS});
    $display("test reset done");
    // internal temperature, negative value split over two registers
    mrdac_conv_model_inst.send(mrdac_pkg::CH_INT_TEMP, 10'h2a5);
    rd_chk(ad(mrdac_pkg::IDX_INT_TEMP), 32'ha9);
    rd_chk(ad(mrdac_pkg::IDX_INT_LOW), 32'h1);
    $display("test internal temperature done");
    // shared slot follows the input select field
    mrdac_conv_model_inst.send(mrdac_pkg::CH_IN1, 10'h136);
    mrdac_conv_model_inst.send(mrdac_pkg::CH_EXT_TEMP, 10'h0ff);
    rd_chk(ad(mrdac_pkg::IDX_EXT_IN1), {24'h0, 8'h4d});
    lowReg[1:0] = 2'h2;
    bus(1'b1, ad(mrdac_pkg::IDX_INPUT_SEL), {29'h0, mrdac_pkg::SEL_EXT_DIODE, 1'b0});
    chk({30'h0, inputSelectField}, {30'h0, mrdac_pkg::SEL_EXT_DIODE});
    bus(1'b1, ad(mrdac_pkg::IDX_INPUT_SEL), 32'h6);
    chk({30'h0, inputSelectField}, {30'h0, mrdac_pkg::SEL_EXT_DIODE});
    mrdac_conv_model_inst.send(mrdac_pkg::CH_EXT_TEMP, 10'h3c9);
    mrdac_conv_model_inst.send(mrdac_pkg::CH_IN1, 10'h001);
    rd_chk(ad(mrdac_pkg::IDX_EXT_IN1), 32'hf2);
    lowReg[1:0] = 2'h1;
    $display("test input select done");
    // inputs two to four with their low bits packed in the shared register
    for (int i = 0; i < 3; i++)
    begin
      mrdac_conv_model_inst.send(inCh[i], inVal[i]);
      lowReg[2 * i + 2 +: 2] = inVal[i][1:0];
      rd_chk(ad(inIdx[i]), {24'h0, inVal[i][9:2]});
    end
    rd_chk(ad(mrdac_pkg::IDX_RES_LOW), {24'h0, lowReg});
    $display("test analog inputs done");
    // writes to result registers change nothing
    bus(1'b1, ad(mrdac_pkg::IDX_INT_TEMP), 32'hff);
    bus(1'b1, ad(mrdac_pkg::IDX_RES_LOW), 32'h00);
    rd_chk(ad(mrdac_pkg::IDX_INT_TEMP), 32'ha9);
    rd_chk(ad(mrdac_pkg::IDX_RES_LOW), {24'h0, lowReg});
    $display("test read-only done");
    // dac codes: high byte above the top nibble of the low register
    bus(1'b1, ad(mrdac_pkg::IDX_DACA_LO), 32'hf0);
    bus(1'b1, ad(mrdac_pkg::IDX_DACA_HI), 32'hab);
    chk({20'h0, dacOutputA}, 32'habf);
    bus(1'b1, ad(mrdac_pkg::IDX_DACB_LO), 32'h30);
    bus(1'b1, ad(mrdac_pkg::IDX_DACB_HI), 32'h5c);
    chk({20'h0, dacOutputB}, 32'h5c3);
    rd_chk(ad(mrdac_pkg::IDX_DACA_HI), 32'hab);
    rd_chk(ad(mrdac_pkg::IDX_DACB_LO), 32'h30);
    chk({20'h0, dacOutputA}, 32'habf);
    $display("test dac codes done");
    // unmapped and misaligned accesses
    bus(1'b0, 8'h80, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    bus(1'b1, 8'h45, 32'h11);
    chk({31'h0, er}, 32'h1);
    chk({20'h0, dacOutputA}, 32'habf);
    $display("test unmapped done");
    // reset in mid-run clears codes and results
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({20'h0, dacOutputA}, 32'h0);
    resetn <= 1'b1;
    rd_chk(ad(mrdac_pkg::IDX_DACB_HI), 32'h0);
    rd_chk(ad(mrdac_pkg::IDX_IN4), 32'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
